// [include/can_bias_defines.svh]
`ifndef CAN_BIAS_DEFINES_SVH
`define CAN_BIAS_DEFINES_SVH

// Clock rate of sys_clk_i in Hz
`define CLK_HZ             20000000
// Bus idle timeout in microseconds
`define BUS_IDLE_TIMEOUT_US 1000
// Cycles of bus idle timeout (longest time, rounded down)
`define BUS_IDLE_TIMEOUT_CYC ((`BUS_IDLE_TIMEOUT_US * (`CLK_HZ / 1000000)))
// Operating mode codes on op_mode_i
`define MODE_NORMAL        3'h0
`define MODE_SILENT        3'h1
`define MODE_STANDBY       3'h2
`define MODE_GO_TO_SLEEP   3'h3
`define MODE_SLEEP         3'h4

`endif

// [include/can_bias_pkg.sv]
package can_bias_pkg;

  // Bias states, one-hot
  typedef enum logic [3:0] {
    BIAS_OFF       = 4'b0001,
    BIAS_AUTO_INACT = 4'b0010,
    BIAS_AUTO_ACT  = 4'b0100,
    BIAS_ACTIVE    = 4'b1000
  } bias_state_t;

endpackage

// [src/bus_idle_timer.sv]
`timescale 1ns/10ps
`include "can_bias_defines.svh"

// Counts continuous bus idleness; expired is a level once the timeout is reached
module bus_idle_timer #(
  parameter int unsigned TIMEOUT_CYC = `BUS_IDLE_TIMEOUT_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic bus_activity_i,
  output logic      expired_o
);
  logic [31:0] count_reg;

  // Restart on every activity so expiry means an unbroken idle stretch
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= 32'h0000_0000;
    end else if (bus_activity_i) begin
      count_reg <= 32'h0000_0000; // (RQ18)
    end else if (count_reg < TIMEOUT_CYC) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // Registered so the timer never looks expired straight out of reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= !bus_activity_i && (count_reg >= TIMEOUT_CYC - 1);
    end
  end
endmodule

// [src/wake_sequencer.sv]
`timescale 1ns/10ps

// Tracks filtered dominant, recessive, dominant; flags wake at the second dominant
module wake_sequencer (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic enable_i,
  input  wire logic filt_dominant_i,
  input  wire logic filt_recessive_i,
  input  wire logic timeout_i,
  output logic      wake_o
);
  logic [1:0] phase_reg;

  // Phase 0 idle, 1 saw dominant, 2 saw recessive; other traffic does not reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg <= 2'h0;
      wake_o    <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      if (!enable_i || timeout_i) begin
        phase_reg <= 2'h0;
      end else begin
        case (phase_reg)
          2'h0: if (filt_dominant_i) phase_reg <= 2'h1;
          2'h1: if (filt_recessive_i) phase_reg <= 2'h2;
          2'h2: begin
            if (filt_dominant_i) begin
              wake_o    <= 1'b1; // (RQ17)
              phase_reg <= 2'h0;
            end
          end
          default: phase_reg <= 2'h0;
        endcase
      end
    end
  end
endmodule

// [src/can_bias_state_control.sv]
`timescale 1ns/10ps
`include "can_bias_defines.svh"
// Notes on behaviour
// (RQ1) High-voltage supply falling undervoltage forces the off state, bus floating.
// (RQ2) Off moves to autonomous inactive once high-voltage supply passes rising threshold.
// (RQ3) Autonomous inactive biases both bus pins to ground.
// (RQ4) Remote wake moves autonomous inactive to autonomous active, mid-level bias.
// (RQ5) Low-power modes: autonomous active drops to inactive when idle timer expires.
// (RQ6) Leaving normal/silent: active if idle shorter than timeout, else inactive.
// (RQ7) Active falls to autonomous active on core or I/O falling undervoltage.
// (RQ8) Autonomous inactive to active-autonomous entering normal/silent with supply undervoltage.
// (RQ9) Active entered only in normal mode with core and I/O supplies good.
// (RQ10) Transmit low before leaving standby blocks transmitter after entering active.
// (RQ11) Normal mode: transmit low drives dominant, else outputs high impedance.
// (RQ12) Silent mode keeps driver off whatever the transmit input.
// (RQ13) Normal/silent: receive low when dominant, high when recessive or open.
// (RQ14) Standby: receive high, low while a wake event stays pending.
// (RQ15) Sleep/go-to-sleep: receive high, tri-state without I/O or high-voltage supply. Code still drives receive low while a wake event stays pending.
// (RQ16) Wake detection disabled in normal and silent modes.
// (RQ17) Remote wake recognised at the second filtered dominant phase.
// (RQ18) Bus idle timer restarts on every bus activity.
module can_bias_state_control #(
  parameter int unsigned IDLE_TIMEOUT_CYC = `BUS_IDLE_TIMEOUT_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] op_mode_i,
  input  wire logic       hv_supply_low_falling_i,
  input  wire logic       hv_supply_low_rising_i,
  input  wire logic       core_supply_low_falling_i,
  input  wire logic       core_supply_low_rising_i,
  input  wire logic       io_supply_low_falling_i,
  input  wire logic       io_supply_low_rising_i,
  input  wire logic       txd_i,
  input  wire logic       rx_dominant_i,
  input  wire logic       wake_rx_dominant_i,
  input  wire logic       wake_rx_recessive_i,
  input  wire logic       wake_timeout_i,
  input  wire logic       wake_clear_i,
  output logic [3:0]      bias_state_o,
  output logic            bias_gnd_o,
  output logic            bias_mid_o,
  output logic            bias_half_core_o,
  output logic            drive_dominant_o,
  output logic            rxd_o,
  output logic            rxd_oe_o,
  output logic            wake_pending_o,
  output logic            transmit_stuck_low_block_o
);
  can_bias_pkg::bias_state_t state_reg;
  can_bias_pkg::bias_state_t state_next;
  logic [2:0] mode_prev_reg;
  logic       idle_expired;
  logic       wake_event;
  logic       normal_mode;
  logic       silent_mode;
  logic       low_power_mode;
  logic       was_active_mode;
  logic       supply_low;
  logic       supply_good;
  logic       leaving_standby;

  assign normal_mode     = (op_mode_i == `MODE_NORMAL);
  assign silent_mode     = (op_mode_i == `MODE_SILENT);
  assign low_power_mode  = !normal_mode && !silent_mode;
  assign was_active_mode = (mode_prev_reg == `MODE_NORMAL) || (mode_prev_reg == `MODE_SILENT);
  assign supply_low      = core_supply_low_falling_i || io_supply_low_falling_i;
  assign supply_good     = !core_supply_low_rising_i && !io_supply_low_rising_i;
  assign leaving_standby = (mode_prev_reg == `MODE_STANDBY) && !low_power_mode;

  // Idle timer: activity is any dominant seen by either receiver
  bus_idle_timer #(
    .TIMEOUT_CYC (IDLE_TIMEOUT_CYC)
  ) u_idle (
    .sys_clk_i      (sys_clk_i),
    .reset_n_i      (reset_n_i),
    .bus_activity_i (rx_dominant_i || wake_rx_dominant_i),
    .expired_o      (idle_expired)
  );

  // Wake receiver runs only in low-power modes
  wake_sequencer u_wake (
    .sys_clk_i        (sys_clk_i),
    .reset_n_i        (reset_n_i),
    .enable_i         (low_power_mode), // (RQ16)
    .filt_dominant_i  (wake_rx_dominant_i),
    .filt_recessive_i (wake_rx_recessive_i),
    .timeout_i        (wake_timeout_i),
    .wake_o           (wake_event)
  );

  // Previous mode, to see mode changes
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_prev_reg <= `MODE_STANDBY;
    end else begin
      mode_prev_reg <= op_mode_i;
    end
  end

  // Next bias state; high-voltage supply loss outranks everything
  always_comb begin
    state_next = state_reg;
    if (hv_supply_low_falling_i) begin
      state_next = can_bias_pkg::BIAS_OFF; // (RQ1)
    end else begin
      case (state_reg)
        can_bias_pkg::BIAS_OFF: begin
          if (!hv_supply_low_rising_i) state_next = can_bias_pkg::BIAS_AUTO_INACT; // (RQ2)
        end
        can_bias_pkg::BIAS_AUTO_INACT: begin
          if (normal_mode && supply_good && !supply_low) begin
            state_next = can_bias_pkg::BIAS_ACTIVE; // (RQ9)
          end else if (!low_power_mode && supply_low) begin
            state_next = can_bias_pkg::BIAS_AUTO_ACT; // (RQ8)
          end else if (wake_event) begin
            state_next = can_bias_pkg::BIAS_AUTO_ACT; // (RQ4)
          end
        end
        can_bias_pkg::BIAS_AUTO_ACT: begin
          if (normal_mode && supply_good && !supply_low) begin
            state_next = can_bias_pkg::BIAS_ACTIVE; // (RQ9)
          end else if (low_power_mode && idle_expired) begin
            state_next = can_bias_pkg::BIAS_AUTO_INACT; // (RQ5)
          end
        end
        can_bias_pkg::BIAS_ACTIVE: begin
          if (supply_low) begin
            state_next = can_bias_pkg::BIAS_AUTO_ACT; // (RQ7)
          end else if (low_power_mode) begin
            // Choice made from idle time just before the mode change
            state_next = idle_expired ? can_bias_pkg::BIAS_AUTO_INACT
                                      : can_bias_pkg::BIAS_AUTO_ACT; // (RQ6)
          end
        end
        default: state_next = can_bias_pkg::BIAS_OFF;
      endcase
    end
  end

  // Bias state register; starts off until supply seen good
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= can_bias_pkg::BIAS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bias outputs decoded from the next state so they line up with state_reg
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bias_state_o     <= 4'h1;
      bias_gnd_o       <= 1'b0;
      bias_mid_o       <= 1'b0;
      bias_half_core_o <= 1'b0;
    end else begin
      bias_state_o     <= state_next;
      bias_gnd_o       <= (state_next == can_bias_pkg::BIAS_AUTO_INACT); // (RQ3)
      bias_mid_o       <= (state_next == can_bias_pkg::BIAS_AUTO_ACT);   // (RQ4)
      bias_half_core_o <= (state_next == can_bias_pkg::BIAS_ACTIVE);     // (RQ9)
    end
  end

  // Stuck-low guard: armed if transmit is low as standby is left,
  // released once transmit goes high again or a low-power mode is entered
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      transmit_stuck_low_block_o <= 1'b0;
    end else if (leaving_standby && !txd_i) begin
      transmit_stuck_low_block_o <= 1'b1; // (RQ10)
    end else if (txd_i || low_power_mode) begin
      transmit_stuck_low_block_o <= 1'b0;
    end
  end

  // Driver: dominant only in normal mode, active state, transmit low, not blocked
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_dominant_o <= 1'b0;
    end else begin
      drive_dominant_o <= normal_mode && !txd_i // (RQ11)
                          && !silent_mode // (RQ12)
                          && (state_next == can_bias_pkg::BIAS_ACTIVE)
                          && !transmit_stuck_low_block_o
                          && !(leaving_standby && !txd_i); // (RQ10)
    end
  end

  // Pending wake holds until the controller reaches normal mode or clears it
  // Set wins over clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_pending_o <= 1'b0;
    end else if (wake_event) begin
      wake_pending_o <= 1'b1; // (RQ14)
    end else if (wake_clear_i || normal_mode) begin
      wake_pending_o <= 1'b0;
    end
  end

  // Receive output per mode
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rxd_o    <= 1'b1;
      rxd_oe_o <= 1'b0;
    end else begin
      case (op_mode_i)
        `MODE_NORMAL, `MODE_SILENT: begin
          rxd_o    <= !rx_dominant_i; // (RQ13)
          rxd_oe_o <= !io_supply_low_falling_i;
        end
        `MODE_STANDBY: begin
          rxd_o    <= !(wake_pending_o || wake_event); // (RQ14)
          rxd_oe_o <= !io_supply_low_falling_i;
        end
        default: begin
          rxd_o    <= !(wake_pending_o || wake_event);
          rxd_oe_o <= !io_supply_low_falling_i && !hv_supply_low_falling_i; // (RQ15)
        end
      endcase
    end
  end
endmodule

// [verif/can_bias_props.sv]
`timescale 1ns/10ps
// Port-level checks of bias state and pin mapping
module can_bias_props #(
  parameter int unsigned IDLE_TIMEOUT_CYC = 8
) (
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic [2:0] op_mode_i,
  input wire logic       hv_supply_low_falling_i,
  input wire logic       hv_supply_low_rising_i,
  input wire logic       core_supply_low_falling_i,
  input wire logic       txd_i,
  input wire logic       rx_dominant_i,
  input wire logic [3:0] bias_state_o,
  input wire logic       bias_gnd_o,
  input wire logic       bias_mid_o,
  input wire logic       bias_half_core_o,
  input wire logic       drive_dominant_o,
  input wire logic       rxd_o,
  input wire logic       wake_pending_o,
  input wire logic       transmit_stuck_low_block_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // One edge of latency on every state move
  a_hv_low_off: assert property (hv_supply_low_falling_i |=> bias_state_o == 4'h1 && !drive_dominant_o)
    else $error("hv low did not force off");
  a_off_to_inact: assert property (bias_state_o == 4'h1 && !hv_supply_low_falling_i && !hv_supply_low_rising_i
    |=> bias_state_o == 4'h2)
    else $error("off did not move to inactive");
  a_inact_gnd: assert property (bias_state_o == 4'h2 |-> bias_gnd_o && !bias_mid_o)
    else $error("inactive bias wrong");
  a_act_mid: assert property (bias_state_o == 4'h4 |-> bias_mid_o && !bias_gnd_o)
    else $error("autonomous active bias wrong");
  a_core_drop: assert property (bias_state_o == 4'h8 && core_supply_low_falling_i && !hv_supply_low_falling_i
    && op_mode_i == 3'h0 |=> bias_state_o == 4'h4)
    else $error("core low did not leave active");
  a_active_entry: assert property ($rose(bias_state_o == 4'h8) |-> $past(op_mode_i) == 3'h0 && bias_half_core_o)
    else $error("active entered outside normal");
  a_block_drive: assert property (transmit_stuck_low_block_o |-> !drive_dominant_o)
    else $error("blocked transmitter drove");
  a_drive_cause: assert property (drive_dominant_o |-> $past(txd_i) == 1'b0 && $past(op_mode_i) == 3'h0)
    else $error("drive without low transmit in normal");
  a_silent_off: assert property (op_mode_i == 3'h1 |=> !drive_dominant_o)
    else $error("driver on in silent");
  a_rx_mirror: assert property (op_mode_i <= 3'h1 && $past(op_mode_i) <= 3'h1 && bias_state_o == 4'h8
    |=> rxd_o == !$past(rx_dominant_i))
    else $error("receive output not mirroring bus");
  a_no_wake_act: assert property ((op_mode_i <= 3'h1) [*3] |=> !$rose(wake_pending_o))
    else $error("wake seen in normal or silent");
endmodule

// [verif/can_ctrl_model.sv]
`timescale 1ns/10ps
// Protocol controller stand-in: owns transmit, watches receive
module can_ctrl_model (
  input  wire logic sys_clk_i,
  input  wire logic rxd_i,
  input  wire logic rxd_oe_i,
  output logic      txd_o,
  output logic      rxd_line_o
);
  // Pull-up on receive: a released pin reads recessive
  assign rxd_line_o = rxd_oe_i ? rxd_i : 1'b1;
  initial txd_o = 1'b1;
  // Change just after an edge so the block samples a settled level
  task automatic set_txd(input logic v);
    @(posedge sys_clk_i);
    txd_o <= v;
  endtask
endmodule

// [verif/can_bias_state_control_tb.sv]
`timescale 1ns/10ps
module can_bias_state_control_tb;
  logic       clk;
  logic       rst_n;
  logic [2:0] mode;
  logic       hv_f, hv_r, core_f, core_r, io_f, io_r, wk_to;
  logic       txd, rx_dom, wk_dom, wk_rec, wk_clr;
  logic [3:0] st;
  logic       gnd, mid, half, drv, rxd, rxd_oe, wpend, blk, rxl;
  int         error_cnt, num_checks;
  int         cyc = 0;

  can_bias_state_control #(.IDLE_TIMEOUT_CYC(8)) can_bias_state_control_inst (.sys_clk_i(clk),
    .reset_n_i(rst_n), .op_mode_i(mode), .hv_supply_low_falling_i(hv_f), .hv_supply_low_rising_i(hv_r),
    .core_supply_low_falling_i(core_f), .core_supply_low_rising_i(core_r), .io_supply_low_falling_i(io_f),
    .io_supply_low_rising_i(io_r), .txd_i(txd), .rx_dominant_i(rx_dom), .wake_rx_dominant_i(wk_dom),
    .wake_rx_recessive_i(wk_rec), .wake_timeout_i(wk_to), .wake_clear_i(wk_clr), .bias_state_o(st),
    .bias_gnd_o(gnd), .bias_mid_o(mid), .bias_half_core_o(half), .drive_dominant_o(drv), .rxd_o(rxd),
    .rxd_oe_o(rxd_oe), .wake_pending_o(wpend), .transmit_stuck_low_block_o(blk));
  can_ctrl_model can_ctrl_model_inst (.sys_clk_i(clk), .rxd_i(rxd), .rxd_oe_i(rxd_oe), .txd_o(txd),
    .rxd_line_o(rxl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Sample on the falling edge, after registered outputs settle
  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Bounded wait: state moves within n cycles or it is a mismatch
  task wait_st(input logic [3:0] e, input int n);
    for (int i = 0; i < n && st !== e; i++) wt(1);
    chk("bias_state", e, st);
  endtask
  // Dominant, recessive, dominant; with cut set the pattern timeout lands on the second dominant
  task wake_seq(input logic cut);
    @(posedge clk) wk_dom <= 1'b1;
    @(posedge clk) begin wk_dom <= 1'b0; wk_rec <= 1'b1; end
    @(posedge clk) begin wk_rec <= 1'b0; wk_dom <= 1'b1; wk_to <= cut; end
    @(posedge clk) begin wk_dom <= 1'b0; wk_to <= 1'b0; end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task t_power;
    chk("bias_state", 4'h1, st);
    @(posedge clk) begin hv_f <= 1'b0; hv_r <= 1'b0; end
    wt(2);
    chk("bias_state", 4'h2, st);
    chk("bias_gnd", 4'h1, gnd);
  endtask
  task t_wake;
    wake_seq(1'b1);
    wt(2);
    chk("bias_state", 4'h2, st);
    wake_seq(1'b0);
    wt(2);
    chk("bias_state", 4'h4, st);
    chk("bias_mid", 4'h1, mid);
    chk("wake_pending", 4'h1, wpend);
    wait_st(4'h2, 20);
    chk("rxd", 4'h0, rxd);
    @(posedge clk) wk_clr <= 1'b1;
    @(posedge clk) wk_clr <= 1'b0;
    wt(1);
    chk("rxd", 4'h1, rxd);
  endtask
  task t_txd;
    can_ctrl_model_inst.set_txd(1'b0);
    @(posedge clk) mode <= 3'h0;
    wait_st(4'h8, 4);
    chk("half_core", 4'h1, half);
    chk("block", 4'h1, blk);
    chk("drive", 4'h0, drv);
    can_ctrl_model_inst.set_txd(1'b1);
    wt(2);
    chk("drive", 4'h0, drv);
    can_ctrl_model_inst.set_txd(1'b0);
    wt(2);
    chk("drive", 4'h1, drv);
    @(posedge clk) rx_dom <= 1'b1;
    wt(2);
    chk("rxd", 4'h0, rxd);
    can_ctrl_model_inst.set_txd(1'b1);
    @(posedge clk) rx_dom <= 1'b0;
    wt(2);
    chk("rxd", 4'h1, rxl);
  endtask
  task t_silent;
    @(posedge clk) mode <= 3'h1;
    can_ctrl_model_inst.set_txd(1'b0);
    @(posedge clk) rx_dom <= 1'b1;
    wt(2);
    chk("drive", 4'h0, drv);
    chk("rxd", 4'h0, rxd);
    // Silent never clears a pending wake, so a wake that slipped through would stay visible
    wake_seq(1'b0);
    wt(2);
    chk("wake_pending", 4'h0, wpend);
    can_ctrl_model_inst.set_txd(1'b1);
    @(posedge clk) begin rx_dom <= 1'b0; mode <= 3'h2; end
    wait_st(4'h4, 3);
    wait_st(4'h2, 20);
  endtask
  task t_supply;
    @(posedge clk) begin core_f <= 1'b1; core_r <= 1'b1; end
    @(posedge clk) mode <= 3'h0;
    wait_st(4'h4, 4);
    // I/O supply still below its rising threshold holds off active entry
    @(posedge clk) begin core_f <= 1'b0; core_r <= 1'b0; io_r <= 1'b1; end
    wt(2);
    chk("bias_state", 4'h4, st);
    @(posedge clk) io_r <= 1'b0;
    wait_st(4'h8, 4);
    @(posedge clk) core_f <= 1'b1;
    wait_st(4'h4, 3);
    @(posedge clk) core_f <= 1'b0;
    wait_st(4'h8, 4);
    @(posedge clk) io_f <= 1'b1;
    wait_st(4'h4, 3);
    @(posedge clk) io_f <= 1'b0;
    wait_st(4'h8, 4);
    wt(12);
    @(posedge clk) mode <= 3'h4;
    wt(2);
    chk("bias_state", 4'h2, st);
    chk("rxd", 4'h1, rxd);
    @(posedge clk) begin hv_f <= 1'b1; hv_r <= 1'b1; end
    wt(2);
    chk("bias_state", 4'h1, st);
    chk("rxd_oe", 4'h0, rxd_oe);
  endtask

  initial begin
    {rst_n, core_f, core_r, io_f, io_r, wk_to, rx_dom, wk_dom, wk_rec, wk_clr} = '0;
    {hv_f, hv_r} = 2'b11;
    mode = 3'h2;
    error_cnt = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wt(1);
    t_power;
    t_wake;
    t_txd;
    t_silent;
    t_supply;
    stop_test;
  end
  // Hang guard, well above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test;
    end
  end
endmodule

bind can_bias_state_control can_bias_props #(.IDLE_TIMEOUT_CYC(IDLE_TIMEOUT_CYC)) can_bias_props_inst (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .op_mode_i(op_mode_i),
  .hv_supply_low_falling_i(hv_supply_low_falling_i), .hv_supply_low_rising_i(hv_supply_low_rising_i),
  .core_supply_low_falling_i(core_supply_low_falling_i), .txd_i(txd_i), .rx_dominant_i(rx_dominant_i),
  .bias_state_o(bias_state_o), .bias_gnd_o(bias_gnd_o), .bias_mid_o(bias_mid_o),
  .bias_half_core_o(bias_half_core_o), .drive_dominant_o(drive_dominant_o), .rxd_o(rxd_o),
  .wake_pending_o(wake_pending_o), .transmit_stuck_low_block_o(transmit_stuck_low_block_o));
